/* shared/beat_if.sv */
// Link between the sequencer and its beat generator.
`timescale 1ns/10ps
interface beat_if;
  logic start;
  logic [15:0] compare;
  logic hold;
  logic sclk;
  logic rise;
  logic fall;
  logic done;

  modport timer (input start, input compare, input hold, output sclk, output rise, output fall, output done);
  modport seq (output start, output compare, output hold, input sclk, input rise, input fall, input done);
endinterface

/* shared/lcd_bus_pkg.sv */
// Shared constants, states and helpers for the parallel LCD bus sequencer.
package lcd_bus_pkg;

  // Module clock rate and its period in nanoseconds.
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Parallel data path width and the half divider and beat count field widths fed to the beat generator.
  localparam int DATA_W = 8;
  localparam int HALF_W = 8;
  localparam int BEATS_W = 7;

  // Fixed beat count of the command phase.
  localparam logic [BEATS_W-1:0] CMD_BEATS = 7'h01;

  // Byte budget of a burst whose beat count field reads zero.
  localparam logic [7:0] MAX_BURST = 8'h80;

  // Resting levels of the bus lines outside a transaction, and of the strobe between read data beats.
  localparam logic CS_IDLE_N = 1'b1;
  localparam logic EN_IDLE_WRITE = 1'b1;
  localparam logic EN_IDLE_READ = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;

  // Sequencer states.
  typedef enum logic [2:0] {
    S_IDLE,
    S_SETUP,
    S_CMD,
    S_GAP,
    S_DATA,
    S_TAIL
  } seq_state_e;

  // Beat generator compare word: upper byte twice the beats minus one, lower byte the half divider.
  // A beat count of zero stands for 128 beats, which the modulo arithmetic gives for free.
  function automatic logic [15:0] beat_compare(input logic [BEATS_W-1:0] beats, input logic [HALF_W-1:0] half);
    logic [7:0] upper;
    upper = {beats, 1'b0} - 8'h01;
    return {upper, half};
  endfunction

endpackage

/* src/beat_timer.sv */
// Dual 8-bit beat generator producing the shift clock of one phase.
`timescale 1ns/10ps
module beat_timer (
  input wire logic i_clk,
  input wire logic i_resetn,
  beat_if.timer bt
);

  typedef struct packed {
    logic run;
    logic sclk;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] half;
    logic rise;
    logic fall;
    logic done;
  } timer_s;

  timer_s q;
  timer_s d;

  //////////////////////////////////////////////////////////////////////////////
  // Low byte divides the clock to half beats; high byte counts shift clock edges.
  // compare word split
  always_comb begin
    d = q;
    d.rise = 1'b0;
    d.fall = 1'b0;
    d.done = 1'b0;
    if (!q.run) begin
      if (bt.start) begin
        d.run = 1'b1;
        d.sclk = 1'b0;
        d.lo = bt.compare[7:0];
        d.half = bt.compare[7:0];
        d.hi = bt.compare[15:8];
      end
    end else if (q.lo != 8'h00) begin
      d.lo = q.lo - 8'h01;
    end else if (!(bt.hold && !q.sclk)) begin
      // A rising edge waits while the sequencer has no byte, so a burst never sends stale data.
      d.lo = q.half;
      d.sclk = !q.sclk;
      d.rise = !q.sclk;
      d.fall = q.sclk;
      if (q.hi == 8'h00) begin
        d.run = 1'b0;
        d.done = 1'b1;
      end else begin
        d.hi = q.hi - 8'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign bt.sclk = q.sclk;
  assign bt.rise = q.rise;
  assign bt.fall = q.fall;
  assign bt.done = q.done;

endmodule // beat_timer

/* src/parallel_lcd_bus_sequencer.sv */
// Sequencer framing command and data beats on a 6800-style parallel LCD bus.
`timescale 1ns/10ps

// Summary of operation
// - A write transaction sends exactly one command beat and then at least one data write beat.
// - The read/write line stays low for the whole of a write transaction, command beat included.
// - Chip select falls before the first beat and rises only after the last beat has completed.
// - Register select is low for the command byte and high for the following data phase.
// - The command byte goes out as one beat, presented at the rising edge of its shift clock on the strobe.
// - Data writes are one beat or a burst, each byte driven at the rising edge of its own shift clock.
// - A read transaction sends one command beat, then at least one data read beat, with read/write held high.
// - Data reads are one beat or a burst, each byte sampled at the falling edge of its shift clock.
// - All eight data lines are driven or sampled together in each beat.
// - The beat generator takes twice the beat count minus one above the half divider itself.
// - The enable strobe is active low on write beats and on every command beat, and active high on read data beats.
module parallel_lcd_bus_sequencer (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_read,
  input wire logic [7:0] i_cmd,
  input wire logic [6:0] i_beats,
  input wire logic [7:0] i_div_half,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_busy,
  output logic o_done,
  output logic o_cs_n,
  output logic o_rs,
  output logic o_rw,
  output logic o_en,
  output logic [7:0] o_data,
  output logic o_data_oe,
  input wire logic [7:0] i_data
);

  typedef struct packed {
    lcd_bus_pkg::seq_state_e st;
    logic rd;
    logic [7:0] cmd;
    logic [6:0] beats;
    logic [7:0] half;
    logic [7:0] left;
    logic hold_full;
    logic [7:0] hold_byte;
    logic cs_n;
    logic rs;
    logic rw;
    logic en;
    logic [7:0] data;
    logic oe;
    logic wr_ready;
    logic [7:0] rd_data;
    logic rd_valid;
    logic busy;
    logic done;
    logic start;
    logic [15:0] compare;
  } seq_s;

  seq_s q;
  seq_s d;

  beat_if bt ();

  //////////////////////////////////////////////////////////////////////////////
  // Beat generator instance; it paces both phases of every transaction.
  beat_timer u_timer (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .bt(bt)
  );

  // Rising edges are held off while a write burst has no byte waiting.
  assign bt.start = q.start;
  assign bt.compare = q.compare;
  assign bt.hold = (q.st == lcd_bus_pkg::S_DATA) && !q.rd && !q.hold_full;

  //////////////////////////////////////////////////////////////////////////////
  // Transaction sequencing, bus line levels and the one-byte write holding stage.
  always_comb begin
    d = q;
    d.start = 1'b0;
    d.rd_valid = 1'b0;
    d.done = 1'b0;
    case (q.st)
      lcd_bus_pkg::S_IDLE: begin
        if (i_start) begin
          d.st = lcd_bus_pkg::S_SETUP;
          d.rd = i_read;
          d.cmd = i_cmd;
          d.beats = i_beats;
          d.half = i_div_half;
          d.left = (i_beats == 7'h00) ? lcd_bus_pkg::MAX_BURST : {1'b0, i_beats};
          d.busy = 1'b1;
          d.cs_n = 1'b0;
          d.rs = 1'b0;
          d.rw = i_read;
          d.oe = 1'b1;
          d.en = lcd_bus_pkg::EN_IDLE_WRITE;
        end
      end
      lcd_bus_pkg::S_SETUP: begin
        d.start = 1'b1;
        d.compare = lcd_bus_pkg::beat_compare(lcd_bus_pkg::CMD_BEATS, q.half);
        d.st = lcd_bus_pkg::S_CMD;
      end
      lcd_bus_pkg::S_CMD: begin
        if (bt.rise) begin
          d.data = q.cmd;
          d.en = 1'b0;
        end
        if (bt.fall) begin
          d.en = 1'b1;
        end
        if (bt.done) begin
          d.st = lcd_bus_pkg::S_GAP;
        end
      end
      lcd_bus_pkg::S_GAP: begin
        // data phase high
        // Select, drive and strobe level move one cycle after the command strobe ends, so the panel
        // latches the command with register select still low and a read command strobe really ends.
        d.rs = 1'b1;
        if (q.rd) begin
          d.oe = 1'b0;
          d.en = lcd_bus_pkg::EN_IDLE_READ;
        end
        d.start = 1'b1;
        d.compare = lcd_bus_pkg::beat_compare(q.beats, q.half);
        d.st = lcd_bus_pkg::S_DATA;
      end
      lcd_bus_pkg::S_DATA: begin
        if (!q.rd) begin
          if (bt.rise) begin
            d.data = q.hold_byte;
            d.hold_full = 1'b0;
            d.en = 1'b0;
          end
          if (bt.fall) begin
            d.en = 1'b1;
          end
        end else begin
          if (bt.rise) begin
            d.en = 1'b1;
          end
          if (bt.fall) begin
            d.en = 1'b0;
            d.rd_data = i_data;
            d.rd_valid = 1'b1;
          end
        end
        if (bt.done) begin
          d.st = lcd_bus_pkg::S_TAIL;
        end
      end
      lcd_bus_pkg::S_TAIL: begin
        d.cs_n = lcd_bus_pkg::CS_IDLE_N;
        d.rs = 1'b0;
        d.rw = 1'b0;
        d.oe = 1'b0;
        d.en = lcd_bus_pkg::EN_IDLE_WRITE;
        d.busy = 1'b0;
        d.done = 1'b1;
        d.st = lcd_bus_pkg::S_IDLE;
      end
      default: begin
        d.st = lcd_bus_pkg::S_IDLE;
      end
    endcase
    // Take a write byte after any consume above, so a take in the same cycle is never lost.
    if (q.wr_ready && i_wr_valid) begin
      d.hold_byte = i_wr_data;
      d.hold_full = 1'b1;
      d.left = q.left - 8'h01;
    end
    d.wr_ready = !d.rd && !d.hold_full && (d.left != 8'h00) &&
      (d.st != lcd_bus_pkg::S_IDLE) && (d.st != lcd_bus_pkg::S_TAIL);
  end

  // State register with defined bus levels under reset.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
      q.st <= lcd_bus_pkg::S_IDLE;
      q.cs_n <= lcd_bus_pkg::CS_IDLE_N;
      q.en <= lcd_bus_pkg::EN_IDLE_WRITE;
      q.data <= lcd_bus_pkg::DATA_RESET;
      q.compare <= lcd_bus_pkg::COMPARE_RESET;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Every output is a field of the state register.
  assign o_wr_ready = q.wr_ready;
  assign o_rd_data = q.rd_data;
  assign o_rd_valid = q.rd_valid;
  assign o_busy = q.busy;
  assign o_done = q.done;
  assign o_cs_n = q.cs_n;
  assign o_rs = q.rs;
  assign o_rw = q.rw;
  assign o_en = q.en;
  assign o_data = q.data;
  assign o_data_oe = q.oe;

endmodule // parallel_lcd_bus_sequencer

/* verification/lcd_panel_model.sv */
// Behavioural LCD panel that records written beats and answers read beats.
`timescale 1ns/10ps
module lcd_panel_model (
  input wire logic i_clk,
  input wire logic i_cs_n,
  input wire logic i_rs,
  input wire logic i_rw,
  input wire logic i_en,
  input wire logic [7:0] i_bus,
  output logic [7:0] o_bus
);
  logic [8:0] log_q [0:255];
  int n_log = 0;
  int low_len = 0;
  int low_cnt = 0;
  logic en_q = 1'b1;
  logic cs_q = 1'b1;
  logic rs_q = 1'b0;
  logic tgl = 1'b0;
  logic [7:0] rd_k = 8'h00;
  // read byte drive
  // Off the read phase the bus wanders each cycle, so a stale byte never passes.
  assign o_bus = (!i_cs_n && i_rw && i_rs) ? 8'h50 + rd_k : {8{tgl}} ^ 8'h5a;
  // Capture each command and write strobe beat and measure its low time.
  always @(posedge i_clk) begin
    tgl <= ~tgl;
    en_q <= i_en;
    cs_q <= i_cs_n;
    rs_q <= i_rs;
    low_cnt <= i_en ? 0 : low_cnt + 1;
    if (cs_q && !i_cs_n) begin
      n_log <= 0;
      rd_k <= 8'h00;
    end
    if (!i_cs_n && !en_q && i_en && (!i_rw || !i_rs)) begin
      log_q[n_log] <= {i_rs, i_bus};
      n_log <= n_log + 1;
      low_len <= low_cnt;
    end
    // next read byte
    // The strobe drop that enters the read phase is not a read beat, so it needs select high before too.
    if (!i_cs_n && i_rw && i_rs && rs_q && en_q && !i_en) begin
      rd_k <= rd_k + 8'h01;
    end
  end
endmodule // lcd_panel_model

/* verification/parallel_lcd_bus_sequencer_props.sv */
// Concurrent checks on the sequencer's bus pins.
`timescale 1ns/10ps
module parallel_lcd_bus_sequencer_props (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_cs_n,
  input wire logic o_rs,
  input wire logic o_rw,
  input wire logic o_en,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_rd_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_rw_steady: assert property (!o_cs_n && !$past(o_cs_n) |-> $stable(o_rw))
    else $error("rw moved inside a transaction");
  a_cmd_first: assert property ($fell(o_cs_n) |-> !o_rs && o_data_oe)
    else $error("transaction did not open with a command");
  a_done_cs: assert property (o_done |-> o_cs_n && !$past(o_cs_n))
    else $error("done without chip select release");
  a_idle_quiet: assert property (o_cs_n |-> o_en && !o_data_oe)
    else $error("bus active while deselected");
  a_read_release: assert property (!o_cs_n && o_rw && o_rs |-> !o_data_oe)
    else $error("bus driven during read data");
  a_write_hold: assert property (!o_en && !$past(o_en) && !o_rw && !o_cs_n |-> $stable(o_data))
    else $error("data changed inside a write beat");
  a_rd_phase: assert property (o_rd_valid |-> o_rw && o_rs)
    else $error("read byte outside read phase");
  a_start_frame: assert property (!o_busy && i_start |=> (o_busy && !o_cs_n) ##1 (!o_cs_n)[*2])
    else $error("start did not open a frame");
endmodule // parallel_lcd_bus_sequencer_props
bind parallel_lcd_bus_sequencer parallel_lcd_bus_sequencer_props i_props (.i_clk, .i_resetn, .i_start, .o_busy,
  .o_done, .o_cs_n, .o_rs, .o_rw, .o_en, .o_data, .o_data_oe, .o_rd_valid);

/* verification/parallel_lcd_bus_sequencer_tb.sv */
// Self-checking bench for the parallel LCD bus sequencer.
`timescale 1ns/10ps
module parallel_lcd_bus_sequencer_tb;
  logic i_clk = 0, i_resetn = 0, i_start = 0, i_read = 0, i_wr_valid = 0;
  logic [7:0] i_cmd = 0, i_div_half = 0, i_wr_data = 0, o_rd_data, o_data, i_data, bus_in;
  logic [6:0] i_beats = 0;
  logic o_wr_ready, o_rd_valid, o_busy, o_done, o_cs_n, o_rs, o_rw, o_en, o_data_oe;
  int errors = 0, n_compared = 0;
  always #25 i_clk = ~i_clk;
  // The design's driver wins the shared bus whenever it is enabled.
  assign i_data = o_data_oe ? o_data : bus_in;
  parallel_lcd_bus_sequencer i_parallel_lcd_bus_sequencer (.i_clk, .i_resetn, .i_start, .i_read, .i_cmd,
    .i_beats, .i_div_half, .i_wr_data, .i_wr_valid, .o_wr_ready, .o_rd_data, .o_rd_valid, .o_busy, .o_done,
    .o_cs_n, .o_rs, .o_rw, .o_en, .o_data, .o_data_oe, .i_data);
  lcd_panel_model i_lcd_panel_model (.i_clk, .i_cs_n(o_cs_n), .i_rs(o_rs), .i_rw(o_rw), .i_en(o_en),
    .i_bus(i_data), .o_bus(bus_in));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One transaction; write bytes are offered with stalls, read bytes compared on arrival.
  task automatic go(input logic rd, input logic [7:0] cmd, input logic [6:0] n, input logic [7:0] h);
    int sent, got, k, nb;
    sent = 0;
    got = 0;
    // A zero beat count stands for the full 128-beat burst.
    nb = (n == 7'h00) ? 128 : int'(n);
    @(posedge i_clk);
    {i_start, i_read, i_cmd, i_beats, i_div_half} <= {1'b1, rd, cmd, n, h};
    @(posedge i_clk);
    i_start <= 1'b0;
    for (k = 0; k < 5000 && !o_done; k++) begin
      @(posedge i_clk);
      if (i_wr_valid && o_wr_ready) sent++;
      // An offered byte stands until it is taken; stalls only fall between bytes.
      if (!i_wr_valid || o_wr_ready) begin
        i_wr_valid <= !rd && sent < nb && k % 3 != 1;
        i_wr_data <= 8'ha0 + 8'(sent);
      end
      if (o_rd_valid) begin
        check("read byte", {1'b0, o_rd_data}, {1'b0, 8'h50 + 8'(got)});
        got++;
      end
    end
    if (k == 5000) begin
      errors++;
      finish_test();
    end
    check("beats seen", 9'(i_lcd_panel_model.n_log), rd ? 9'h001 : 9'(nb) + 9'h001);
    check("command beat", i_lcd_panel_model.log_q[0], {1'b0, cmd});
    check("strobe low", 9'(i_lcd_panel_model.low_len), 9'(h) + 9'h001);
    if (rd) check("read count", 9'(got), 9'(nb));
    for (k = 1; !rd && k <= nb; k++) check("data beat", i_lcd_panel_model.log_q[k], {1'b1, 8'ha0 + 8'(k - 1)});
    $display("test done cmd %h beats %0d", cmd, nb);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_write_single; go(1'b0, 8'h2c, 7'h01, 8'h00); endtask
  task automatic t_write_burst; go(1'b0, 8'h3c, 7'h03, 8'h02); endtask
  task automatic t_read_single; go(1'b1, 8'h2e, 7'h01, 8'h00); endtask
  task automatic t_read_burst; go(1'b1, 8'h3e, 7'h04, 8'h01); endtask
  task automatic t_write_max; go(1'b0, 8'h2c, 7'h00, 8'h00); endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_write_single();
    t_write_burst();
    t_read_single();
    t_read_burst();
    t_write_max();
    t_write_single();
    finish_test();
  end
endmodule // parallel_lcd_bus_sequencer_tb
